// [hw/guard_ctl.sv]
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module guard_ctl
  import guard_ctl_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [ADDR_W-1:0]       flash_addr,
  output logic [DATA_W-1:0]       flash_dq_out,
  output logic                    flash_dq_oe_n,
  input  wire logic [DATA_W-1:0]  flash_dq_in,
  output logic                    flash_ce_n,
  output logic                    flash_we_n,
  output logic                    flash_oe_n
);
  initial begin
    if (ADDR_W != 24 || DATA_W != 16) $error("guard_ctl supports 24 address and 16 data bits only");
  end

  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_SETUP, S_STROBE, S_HOLD, S_NEXT} state_t;

  typedef struct packed {
    state_t      st;
    logic [3:0]  op;
    logic [2:0]  idx;
    logic [7:0]  sector;
    logic [1:0]  cnt;
    logic [15:0] rdata;
    logic        tmo;
    logic        busy;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [23:0] addr;
    logic [15:0] dq;
    logic        dq_oe_n;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
  } ctl_t;

  ctl_t cur;
  ctl_t next_cur;

  logic [23:0] rom_addr;
  logic [15:0] rom_data;
  logic        rom_rd;
  logic        rom_last;

  cycle_rom u_rom (
    .pclk    (pclk),
    .presetn (presetn),
    .op      (cur.op),
    .idx     (cur.idx),
    .sector  (cur.sector),
    .addr    (rom_addr),
    .data    (rom_data),
    .rd      (rom_rd),
    .last    (rom_last)
  );

  function automatic logic known_op(input logic [3:0] o);
    known_op = (o >= 4'(OP_PERS_SET)) && (o <= 4'(OP_ARRAY_READ));
  endfunction

  logic access;
  assign access = psel && penable && !cur.pready;

  always_comb begin
    next_cur = cur;
    next_cur.pready = 1'b0;
    next_cur.pslverr = 1'b0;
    if (access) begin
      next_cur.pready = 1'b1;
      if (pwrite) begin
        case (paddr)
          REG_CTRL: begin
            // Unknown or busy-time commands refused so no stray cycle is sent
            if (cur.busy || !known_op(pwdata[CTRL_OP_LSB +: CTRL_OP_W])) begin
              next_cur.pslverr = 1'b1;
            end else begin
              next_cur.op   = pwdata[CTRL_OP_LSB +: CTRL_OP_W];
              next_cur.busy = 1'b1;
              next_cur.idx  = 3'd0;
              next_cur.st   = S_LOAD;
              if (pwdata[CTRL_OP_LSB +: CTRL_OP_W] == 4'(OP_RESET)) next_cur.tmo = 1'b0;
            end
          end
          REG_SECTOR: next_cur.sector = pwdata[SECT_LSB +: 8];
          default:    next_cur.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          REG_SECTOR: next_cur.prdata = {8'h00, cur.sector, 16'h0000};
          REG_STATUS: next_cur.prdata = {29'h0, cur.rdata[0] == 1'b0, cur.tmo, cur.busy};
          REG_RDATA:  next_cur.prdata = {16'h0000, cur.rdata};
          REG_ARRAY:  next_cur.prdata = {16'h0000, cur.rdata};
          REG_CTRL:   next_cur.prdata = {28'h0, cur.op};
          default: begin
            next_cur.prdata  = 32'h0;
            next_cur.pslverr = 1'b1;
          end
        endcase
      end
    end
    case (cur.st)
      S_IDLE: begin
        next_cur.ce_n = 1'b1;
      end
      S_LOAD: begin
        // One cycle for the table register to settle on the new index
        next_cur.st = S_SETUP;
      end
      S_SETUP: begin
        next_cur.addr    = rom_addr;
        next_cur.dq      = rom_data;
        next_cur.ce_n    = 1'b0;
        next_cur.dq_oe_n = rom_rd;
        next_cur.oe_n    = !rom_rd;
        next_cur.we_n    = rom_rd;
        next_cur.cnt     = 2'(BUS_CYCLES);
        next_cur.st      = S_STROBE;
      end
      S_STROBE: begin
        if (cur.cnt != 2'd0) begin
          next_cur.cnt = cur.cnt - 2'd1;
        end else begin
          if (!cur.oe_n) begin
            next_cur.rdata = flash_dq_in;
            // Timeout flag during status output sets the sticky tmo bit, cleared only by a reset command
            if (flash_dq_in[TIMEOUT_BIT] && cur.op != 4'(OP_ARRAY_READ)) next_cur.tmo = 1'b1;
          end
          next_cur.we_n = 1'b1;
          next_cur.oe_n = 1'b1;
          next_cur.st   = S_HOLD;
        end
      end
      S_HOLD: begin
        next_cur.ce_n    = 1'b1;
        next_cur.dq_oe_n = 1'b1;
        next_cur.st      = S_NEXT;
        if (rom_last) begin
          next_cur.busy = 1'b0;
          next_cur.st   = S_IDLE;
        end
      end
      S_NEXT: begin
        next_cur.idx = cur.idx + 3'd1;
        next_cur.st  = S_LOAD;
      end
      default: next_cur.st = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{st: S_IDLE, op: 4'h0, idx: 3'd0, sector: 8'h00, cnt: 2'd0, rdata: 16'h0000,
               tmo: 1'b0, busy: 1'b0, prdata: 32'h0, pready: 1'b0, pslverr: 1'b0,
               addr: 24'h0, dq: 16'h0, dq_oe_n: 1'b1, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata        = cur.prdata;
  assign pready        = cur.pready;
  assign pslverr       = cur.pslverr;
  assign flash_addr    = cur.addr;
  assign flash_dq_out  = cur.dq;
  assign flash_dq_oe_n = cur.dq_oe_n;
  assign flash_ce_n    = cur.ce_n;
  assign flash_we_n    = cur.we_n;
  assign flash_oe_n    = cur.oe_n;

  chk_write_read_excl: assert property (@(posedge pclk) disable iff (!presetn)
    !(flash_we_n == 1'b0 && flash_oe_n == 1'b0)) else $error("write and read strobes overlap");
  chk_drive_on_write: assert property (@(posedge pclk) disable iff (!presetn)
    !flash_we_n |-> !flash_dq_oe_n) else $error("write strobe without data drive");
  chk_release_on_read: assert property (@(posedge pclk) disable iff (!presetn)
    !flash_oe_n |-> flash_dq_oe_n) else $error("bus driven during read");
  chk_strobe_width: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n) else $error("write strobe width wrong");
  chk_reset_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(flash_we_n) && cur.op == 4'(OP_RESET) |-> flash_dq_out == D_F0) else $error("reset data wrong");
  chk_unlock_first: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(flash_we_n) && cur.idx == 3'd0 && cur.op != 4'(OP_RESET) |-> flash_dq_out == D_AA
    && flash_addr == ADDR_UNLOCK1) else $error("first unlock cycle wrong");
  chk_busy_ends: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cur.busy) |-> ##[1:60] !cur.busy) else $error("sequence did not finish");
  chk_tmo_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    cur.tmo && !cur.busy |=> cur.tmo || cur.op == 4'(OP_RESET)) else $error("timeout flag lost");
  cov_pers_set: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(cur.busy) && cur.op == 4'(OP_PERS_SET));
  cov_vol_read: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(cur.busy) && cur.op == 4'(OP_VOL_READ));
  cov_timeout: cover property (@(posedge pclk) disable iff (!presetn) $rose(cur.tmo));
endmodule // guard_ctl

// [hw/guard_ctl_pkg.sv]
package guard_ctl_pkg;
  localparam logic [31:0] REG_CTRL   = 32'h0000_0000;
  localparam logic [31:0] REG_SECTOR = 32'h0000_0004;
  localparam logic [31:0] REG_STATUS = 32'h0000_0008;
  localparam logic [31:0] REG_RDATA  = 32'h0000_000C;
  localparam logic [31:0] REG_ARRAY  = 32'h0000_0010;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W   = 4;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_TMO    = 1;
  localparam int STAT_SET    = 2;
  localparam int SECT_LSB    = 16;
  localparam int TIMEOUT_BIT = 5;
  localparam int BUS_CYCLES  = 2;
  localparam logic [23:0] ADDR_UNLOCK1 = 24'h00_0555;
  localparam logic [23:0] ADDR_UNLOCK2 = 24'h00_02AA;
  localparam logic [23:0] ADDR_ZERO    = 24'h00_0000;
  localparam logic [15:0] D_AA   = 16'h00AA;
  localparam logic [15:0] D_55   = 16'h0055;
  localparam logic [15:0] D_PERS = 16'h00C0;
  localparam logic [15:0] D_FRZ  = 16'h0050;
  localparam logic [15:0] D_VOL  = 16'h00E0;
  localparam logic [15:0] D_A0   = 16'h00A0;
  localparam logic [15:0] D_80   = 16'h0080;
  localparam logic [15:0] D_30   = 16'h0030;
  localparam logic [15:0] D_90   = 16'h0090;
  localparam logic [15:0] D_F0   = 16'h00F0;
  localparam logic [15:0] D_0    = 16'h0000;
  localparam logic [15:0] D_1    = 16'h0001;
  typedef enum logic [3:0] {
    OP_NONE, OP_PERS_SET, OP_PERS_ERASE_ALL, OP_PERS_READ, OP_FRZ_CLEAR, OP_FRZ_READ,
    OP_VOL_SET, OP_VOL_CLEAR, OP_VOL_READ, OP_RESET, OP_ARRAY_READ
  } op_t;
  typedef enum logic [1:0] {CS_PERS, CS_FRZ, CS_VOL} cmdset_t;
endpackage

// [hw/cycle_rom.sv]
`timescale 1ns/1ps
module cycle_rom
  import guard_ctl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  op,
  input  wire logic [2:0]  idx,
  input  wire logic [7:0]  sector,
  output logic [23:0]      addr,
  output logic [15:0]      data,
  output logic             rd,
  output logic             last
);
  logic [23:0] sa;
  logic [23:0] a_n;
  logic [15:0] d_n;
  logic        r_n;
  logic        l_n;
  function automatic logic [15:0] entry_code(input logic [3:0] o);
    case (o)
      4'(OP_FRZ_CLEAR), 4'(OP_FRZ_READ):                 entry_code = D_FRZ;
      4'(OP_VOL_SET), 4'(OP_VOL_CLEAR), 4'(OP_VOL_READ): entry_code = D_VOL;
      default:                                           entry_code = D_PERS;
    endcase
  endfunction
  // No buffered write is ever issued, so no abort state can arise
  // Low sector bits zero; any address in the sector serves
  assign sa = {sector, 16'h0000};
  always_comb begin
    a_n = ADDR_ZERO;
    d_n = D_0;
    r_n = 1'b0;
    l_n = 1'b0;
    if (op == 4'(OP_RESET)) begin
      d_n = D_F0;
      l_n = 1'b1;
    end else if (op == 4'(OP_ARRAY_READ)) begin
      r_n = 1'b1;
      l_n = 1'b1;
    end else begin
      // Entry, body, exit; every command step a write except the read step
      case (idx)
        3'd0: begin a_n = ADDR_UNLOCK1; d_n = D_AA; end
        3'd1: begin a_n = ADDR_UNLOCK2; d_n = D_55; end
        3'd2: begin a_n = ADDR_UNLOCK1; d_n = entry_code(op); end
        3'd3: begin
          case (op)
            4'(OP_PERS_ERASE_ALL): d_n = D_80;
            4'(OP_PERS_READ), 4'(OP_VOL_READ): begin
              a_n = sa; r_n = 1'b1;
            end
            4'(OP_FRZ_READ): r_n = 1'b1;
            default: d_n = D_A0;
          endcase
        end
        3'd4: begin
          case (op)
            4'(OP_PERS_SET):       begin a_n = sa; d_n = D_0; end
            4'(OP_PERS_ERASE_ALL): d_n = D_30;
            4'(OP_FRZ_CLEAR):      d_n = D_0;
            4'(OP_VOL_SET):        begin a_n = sa; d_n = D_0; end
            4'(OP_VOL_CLEAR):      begin a_n = sa; d_n = D_1; end
            default:               d_n = D_90;
          endcase
        end
        3'd5: begin
          case (op)
            4'(OP_PERS_READ), 4'(OP_FRZ_READ), 4'(OP_VOL_READ): begin
              d_n = D_0; l_n = 1'b1;
            end
            default: d_n = D_90;
          endcase
        end
        default: begin d_n = D_0; l_n = 1'b1; end
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr <= ADDR_ZERO;
      data <= D_0;
      rd   <= 1'b0;
      last <= 1'b0;
    end else begin
      addr <= a_n;
      data <= d_n;
      rd   <= r_n;
      last <= l_n;
    end
  end
endmodule // cycle_rom

// [dv/flash_guard_model.sv]
`timescale 1ns/1ps
// Behavioural flash: guard command sets only, no suspend or lock register
// Suspend, resume, query and lock register commands never reach this model,
// so their refusal rules stay unexercised here
module flash_guard_model #(
  parameter logic [15:0] ARRAY_WORD = 16'h5A3C
) (
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [23:0] addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe_n,
  input  wire logic        tmo_en,
  output logic [15:0]      dq_in
);
  logic [255:0] pers = '1;
  logic [255:0] vol  = '1;
  logic         frz  = 1'b1;
  logic [1:0]   mode = 2'd0;
  logic [1:0]   ustep = 2'd0;
  logic [7:0]   pend = 8'h00;
  logic [15:0]  idle = 16'hFFFF;
  logic [15:0]  rv;
  logic         gbit;
  wire  [7:0]   d   = dq_out[7:0];
  wire  [7:0]   sec = addr[23:16];
  wire  [10:0]  a   = addr[10:0];

  always_comb begin
    gbit = (mode == 2'd1) ? pers[sec] : (mode == 2'd2) ? frz : vol[sec];
    rv   = (mode == 2'd0) ? ARRAY_WORD : {10'h000, tmo_en, 4'h0, gbit};
  end
  // Released bus shows no stale value
  assign dq_in = (!ce_n && !oe_n) ? rv : idle;
  always @(posedge oe_n) idle <= ~rv;

  always @(posedge we_n) if (!ce_n && !dq_oe_n) begin
    if (d == 8'hF0) begin
      mode  <= 2'd0;
      pend  <= 8'h00;
      ustep <= 2'd0;
    end else if (pend == 8'hA0) begin
      if (mode == 2'd1 && d == 8'h00) pers[sec] <= 1'b0;
      if (mode == 2'd2 && d == 8'h00) frz <= 1'b0;
      if (mode == 2'd3 && d <= 8'h01) vol[sec] <= d[0];
      pend <= 8'h00;
    end else if (pend == 8'h80) begin
      if (d == 8'h30 && addr == 24'h000000) pers <= '1;
      pend <= 8'h00;
    end else if (pend == 8'h90) begin
      if (d == 8'h00) mode <= 2'd0;
      pend <= 8'h00;
    end else if (mode != 2'd0) begin
      if (d == 8'hA0 || d == 8'h80 || d == 8'h90) pend <= d;
    end else if (ustep == 2'd0 && a == 11'h555 && d == 8'hAA) begin
      ustep <= 2'd1;
    end else if (ustep == 2'd1 && a == 11'h2AA && d == 8'h55) begin
      ustep <= 2'd2;
    end else begin
      ustep <= 2'd0;
      if (ustep == 2'd2 && a == 11'h555 && d == 8'hC0) mode <= 2'd1;
      if (ustep == 2'd2 && a == 11'h555 && d == 8'h50) mode <= 2'd2;
      if (ustep == 2'd2 && a == 11'h555 && d == 8'hE0) mode <= 2'd3;
    end
  end
endmodule // flash_guard_model

// [dv/tb_sector_protection_command_decoder.sv]
`timescale 1ns/1ps
module tb_sector_protection_command_decoder;
  import guard_ctl_pkg::*;
  localparam logic [15:0] ARRAY_WORD = 16'h5A3C;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tmo_en = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
  logic [23:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  int          n_fail = 0;
  int          n_tests = 0;

  always #2.5 pclk = ~pclk;

  guard_ctl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
  flash_guard_model #(.ARRAY_WORD(ARRAY_WORD)) m (.ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
    .addr(flash_addr), .dq_out(flash_dq_out), .dq_oe_n(flash_dq_oe_n), .tmo_en(tmo_en), .dq_in(flash_dq_in));

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    if (k >= 50) n_fail++;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  task run_op(input op_t o, input logic [7:0] s);
    int k;
    k = 0;
    apb(1'b1, REG_SECTOR, {8'h00, s, 16'h0000});
    apb(1'b1, REG_CTRL, {28'h0000000, o});
    check({31'h0, err}, 32'h0);
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (rd[STAT_BUSY] !== 1'b0 && k < 200);
    if (k >= 200) n_fail++;
    check({30'h0, m.mode}, 32'h0);
  endtask

  // Guard read: bit0 of the read word and the protected flag must be opposite
  task read_bit(input op_t o, input logic [7:0] s, input logic exp);
    run_op(o, s);
    apb(1'b0, REG_RDATA, 32'h0);
    check({31'h0, rd[0]}, {31'h0, exp});
    apb(1'b0, REG_STATUS, 32'h0);
    check({31'h0, rd[STAT_SET]}, {31'h0, ~exp});
  endtask

  task t_pers;
    read_bit(OP_PERS_READ, 8'h3C, 1'b1);
    run_op(OP_PERS_SET, 8'h3C);
    read_bit(OP_PERS_READ, 8'h3C, 1'b0);
    read_bit(OP_PERS_READ, 8'h3D, 1'b1);
    run_op(OP_PERS_ERASE_ALL, 8'h00);
    read_bit(OP_PERS_READ, 8'h3C, 1'b1);
    $display("t_pers done");
  endtask

  task t_vol;
    run_op(OP_VOL_SET, 8'hFF);
    read_bit(OP_VOL_READ, 8'hFF, 1'b0);
    read_bit(OP_VOL_READ, 8'h00, 1'b1);
    run_op(OP_VOL_CLEAR, 8'hFF);
    read_bit(OP_VOL_READ, 8'hFF, 1'b1);
    $display("t_vol done");
  endtask

  task t_frz;
    read_bit(OP_FRZ_READ, 8'h00, 1'b1);
    run_op(OP_FRZ_CLEAR, 8'h00);
    read_bit(OP_FRZ_READ, 8'hA5, 1'b0);
    $display("t_frz done");
  endtask

  task t_tmo;
    tmo_en <= 1'b1;
    run_op(OP_VOL_READ, 8'h11);
    apb(1'b0, REG_STATUS, 32'h0);
    check({31'h0, rd[STAT_TMO]}, 32'h1);
    tmo_en <= 1'b0;
    run_op(OP_RESET, 8'h00);
    apb(1'b0, REG_STATUS, 32'h0);
    check({31'h0, rd[STAT_TMO]}, 32'h0);
    $display("t_tmo done");
  endtask

  task t_arr;
    run_op(OP_ARRAY_READ, 8'h00);
    apb(1'b0, REG_RDATA, 32'h0);
    check({16'h0000, rd[15:0]}, {16'h0000, ARRAY_WORD});
    apb(1'b0, 32'h0000_0020, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, REG_CTRL, 32'h0000_000F);
    check({31'h0, err}, 32'h1);
    check({30'h0, m.mode}, 32'h0);
    $display("t_arr done");
  endtask

  task conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    conclude;
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_pers;
    t_vol;
    t_frz;
    t_tmo;
    t_arr;
    conclude;
  end
endmodule // tb_sector_protection_command_decoder
